/* core/hs_tuning_consts.vh */
// Operation
// - line drive bits 15:12 hold amplitude code, reset 1010, sent to driver
// - bit 11 enables transmitter, reset 1; forced off by pin low or 1.15
// - bit 10 set freezes equalizer and long-tail correction; clear adapts
// - bits 9:8 transmit rate: full, half, quarter, eighth; reset full
// - bits 7:6 gain policy; reset 01; 10 forces off, 11 on
// - bits 5:4 auto-zero calibration mode; reset 00 calibrates on enable
// - bit 3 enables receiver, reset 1; forced off by pin low or 1.15
// - bits 2:0 receive rate; 000,101,110,111 valid; software avoids others
// - line drive register at 0x03 resets to 0xA848
// - receive tune register at 0x04 resets to 0x1500
// - tune bit 15 forces receiver ADC into track mode
// - tune bits 14:12 precursor equalizer, 111 disables, reset 001
// - tune bits 11:10 recovery loop order; software avoids code 11
// - tune bits 9:8 vote threshold 4/8/16/32, reset eight
// - tune bit 6 disables high-frequency peaking, for rates below 6 Gbps
// - tune bit 5 selects short-channel clock recovery
// - tune bits 4:0 cursor reduction, reset zero; middle codes unused
// - amplitude codes map to rising swing, 130 mV to 1400 mV
`ifndef HS_TUNING_CONSTS_VH
`define HS_TUNING_CONSTS_VH

`define LINE_DRIVE_OFS 5'h03
`define RECEIVE_TUNE_OFS 5'h04
`define LINE_DRIVE_RESET 16'hA848
`define RECEIVE_TUNE_RESET 16'h1500

`define AMP_MSB 15
`define AMP_LSB 12
`define TX_EN_BIT 11
`define EQ_FREEZE_BIT 10
`define TX_RATE_MSB 9
`define TX_RATE_LSB 8
`define GAIN_MSB 7
`define GAIN_LSB 6
`define CAL_MSB 5
`define CAL_LSB 4
`define RX_EN_BIT 3
`define RX_RATE_MSB 2
`define RX_RATE_LSB 0

`define TRACK_BIT 15
`define PRE_EQ_MSB 14
`define PRE_EQ_LSB 12
`define LOOP_MSB 11
`define LOOP_LSB 10
`define VOTE_MSB 9
`define VOTE_LSB 8
`define PEAK_OFF_BIT 6
`define SHORT_CH_BIT 5
`define CURSOR_MSB 4
`define CURSOR_LSB 0

`define PREAMBLE_ONES 6'd32
`define HEADER_BITS 5'd13
`define OP_WRITE 2'b01
`define OP_READ 2'b10

`endif

/* core/cfg_word_reg.v */
`default_nettype none
module cfg_word_reg #(
  parameter WIDTH = 16,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
  input wire mclk,
  input wire sys_rst,
  input wire wrEn,
  input wire [WIDTH-1:0] wrData,
  output reg [WIDTH-1:0] value
);
  // value holds until the next write or reset
  always @(posedge mclk)
  begin
    if (sys_rst)
      value <= RESET_VALUE;
    else if (wrEn)
      value <= wrData;
  end
endmodule // cfg_word_reg
`default_nettype wire

/* core/swing_level_map.v */
`default_nettype none
module swing_level_map (
  input wire mclk,
  input wire sys_rst,
  input wire [3:0] code,
  output reg [10:0] swingMv
);
  reg [10:0] next_swingMv;

  // typical differential swing in mV peak-to-peak
  always @*
  begin
    case (code)
      4'h0: next_swingMv = 11'd130;
      4'h1: next_swingMv = 11'd220;
      4'h2: next_swingMv = 11'd300;
      4'h3: next_swingMv = 11'd390;
      4'h4: next_swingMv = 11'd480;
      4'h5: next_swingMv = 11'd570;
      4'h6: next_swingMv = 11'd660;
      4'h7: next_swingMv = 11'd750;
      4'h8: next_swingMv = 11'd830;
      4'h9: next_swingMv = 11'd930;
      4'hA: next_swingMv = 11'd1020;
      4'hB: next_swingMv = 11'd1110;
      4'hC: next_swingMv = 11'd1180;
      4'hD: next_swingMv = 11'd1270;
      4'hE: next_swingMv = 11'd1340;
      default: next_swingMv = 11'd1400;
    endcase
  end

  always @(posedge mclk)
  begin
    if (sys_rst)
      swingMv <= 11'd0;
    else
      swingMv <= next_swingMv;
  end
endmodule // swing_level_map
`default_nettype wire

/* core/hs_serdes_tuning_regs.v */
`include "hs_tuning_consts.vh"
`default_nettype none
module hs_serdes_tuning_regs (
  input wire mclk,
  input wire sys_rst,
  input wire mdc,
  input wire mdioIn,
  output reg mdioOut,
  output reg mdioOe,
  input wire [4:0] phyAddr,
  input wire channelPowerdownPinN,
  input wire globalPowerDown,
  output reg [3:0] txAmplitudeSel,
  output wire [10:0] txSwingMv,
  output reg txDriverEnable,
  output reg equalizerFreeze,
  output reg [1:0] txRateDiv,
  output reg [1:0] gainLoopPolicy,
  output reg [1:0] offsetCalMode,
  output reg rxFrontEnable,
  output reg [2:0] rxRateDiv,
  output reg adcTrackForce,
  output reg [2:0] rxPrecursorEq,
  output reg [1:0] recoveryLoopOrder,
  output reg [1:0] recoveryVoteThreshold,
  output reg hfPeakingOff,
  output reg shortChannelRecovery,
  output reg [4:0] txCursorReduction
);
  localparam ST_PRE = 2'd0;
  localparam ST_HDR = 2'd1;
  localparam ST_TA = 2'd2;
  localparam ST_DAT = 2'd3;

  reg [1:0] state;
  reg mdcPrev;
  reg [5:0] preCnt;
  reg [4:0] bitCnt;
  reg [11:0] hdr;
  reg [15:0] shiftIn;
  reg [15:0] shiftOut;
  reg isRead;
  reg hit;
  reg regSel;
  reg wrDrive;
  reg wrTune;
  reg [15:0] wrData;
  reg [15:0] readWord;
  reg powerForcedOff;
  reg next_txDriverEnable;
  reg next_rxFrontEnable;

  wire [15:0] lineDrive;
  wire [15:0] receiveTune;
  wire mdcRise;
  wire mdcFall;
  wire [12:0] hdrFull;
  wire [1:0] opCode;
  wire [4:0] frameAddr;
  wire [4:0] frameReg;
  wire regMatch;
  wire frameHit;
  wire tuneSel;
  wire headerOk;

  // mdc is taken as synchronous, so the edges are found from one stored copy
  assign mdcRise = mdc & ~mdcPrev;
  assign mdcFall = ~mdc & mdcPrev;

  // second start bit, opcode, port address, register address
  assign hdrFull = {hdr, mdioIn};
  assign opCode = hdrFull[11:10];
  assign frameAddr = hdrFull[9:5];
  assign frameReg = hdrFull[4:0];
  assign regMatch = (frameReg == `LINE_DRIVE_OFS) || (frameReg == `RECEIVE_TUNE_OFS);
  assign tuneSel = (frameReg == `RECEIVE_TUNE_OFS);
  assign frameHit = (frameAddr == phyAddr) && regMatch;
  // a bad start bit or opcode drops the frame and the preamble hunt restarts
  assign headerOk = hdrFull[12] && (opCode == `OP_WRITE || opCode == `OP_READ);

  // unmapped addresses never drive the line, so their word is only a filler
  always @*
  begin
    case (frameReg)
      `LINE_DRIVE_OFS: readWord = lineDrive;
      `RECEIVE_TUNE_OFS: readWord = receiveTune;
      default: readWord = 16'hFFFF;
    endcase
  end

  cfg_word_reg #(
    .WIDTH(16),
    .RESET_VALUE(`LINE_DRIVE_RESET)
  ) u_line_drive (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .wrEn(wrDrive),
    .wrData(wrData),
    .value(lineDrive)
  );

  cfg_word_reg #(
    .WIDTH(16),
    .RESET_VALUE(`RECEIVE_TUNE_RESET)
  ) u_receive_tune (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .wrEn(wrTune),
    .wrData(wrData),
    .value(receiveTune)
  );

  swing_level_map u_swing (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .code(txAmplitudeSel),
    .swingMv(txSwingMv)
  );

  // management frame engine
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state <= ST_PRE;
      mdcPrev <= 1'b0;
      preCnt <= 6'd0;
      bitCnt <= 5'd0;
      hdr <= 12'h000;
      shiftIn <= 16'h0000;
      shiftOut <= 16'h0000;
      isRead <= 1'b0;
      hit <= 1'b0;
      regSel <= 1'b0;
      wrDrive <= 1'b0;
      wrTune <= 1'b0;
      wrData <= 16'h0000;
      mdioOut <= 1'b0;
      mdioOe <= 1'b0;
    end
    else
    begin
      mdcPrev <= mdc;
      wrDrive <= 1'b0;
      wrTune <= 1'b0;
      case (state)
        ST_PRE:
        begin
          // released on the falling edge after the last read bit
          if (mdcFall)
          begin
            mdioOe <= 1'b0;
            mdioOut <= 1'b0;
          end
          if (mdcRise)
          begin
            if (mdioIn)
            begin
              if (preCnt != `PREAMBLE_ONES)
                preCnt <= preCnt + 6'd1;
            end
            else if (preCnt == `PREAMBLE_ONES)
            begin
              state <= ST_HDR;
              bitCnt <= 5'd0;
              hdr <= 12'h000;
              preCnt <= 6'd0;
            end
            else
              preCnt <= 6'd0;
          end
        end
        ST_HDR:
        begin
          if (mdcRise)
          begin
            hdr <= hdrFull[11:0];
            if (bitCnt == `HEADER_BITS - 5'd1)
            begin
              bitCnt <= 5'd0;
              isRead <= (opCode == `OP_READ);
              hit <= frameHit;
              regSel <= tuneSel;
              // stored values read back as they stand at the header's end
              shiftOut <= readWord;
              if (headerOk)
                state <= ST_TA;
              else
                state <= ST_PRE;
            end
            else
              bitCnt <= bitCnt + 5'd1;
          end
        end
        ST_TA:
        begin
          // first turnaround bit left floating, second driven low
          if (mdcFall && isRead && hit && bitCnt == 5'd1)
          begin
            mdioOe <= 1'b1;
            mdioOut <= 1'b0;
          end
          if (mdcRise)
          begin
            if (bitCnt == 5'd1)
            begin
              state <= ST_DAT;
              bitCnt <= 5'd0;
            end
            else
              bitCnt <= bitCnt + 5'd1;
          end
        end
        ST_DAT:
        begin
          if (mdcFall && isRead && hit)
          begin
            mdioOe <= 1'b1;
            mdioOut <= shiftOut[15];
            shiftOut <= {shiftOut[14:0], 1'b0};
          end
          if (mdcRise)
          begin
            shiftIn <= {shiftIn[14:0], mdioIn};
            if (bitCnt == 5'd15)
            begin
              state <= ST_PRE;
              bitCnt <= 5'd0;
              // reserved codes are stored as written; software keeps clear of them
              if (!isRead && hit)
              begin
                wrData <= {shiftIn[14:0], mdioIn};
                wrDrive <= ~regSel;
                wrTune <= regSel;
              end
            end
            else
              bitCnt <= bitCnt + 5'd1;
          end
        end
        default:
          state <= ST_PRE;
      endcase
    end
  end

  // one override for both enables, so a power down drops them together
  always @*
  begin
    powerForcedOff = ~channelPowerdownPinN | globalPowerDown;
    next_txDriverEnable = lineDrive[`TX_EN_BIT] & ~powerForcedOff;
    next_rxFrontEnable = lineDrive[`RX_EN_BIT] & ~powerForcedOff;
  end

  // static line drive outputs, one cycle behind the stored word
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      txAmplitudeSel <= 4'hA;
      txDriverEnable <= 1'b0;
      equalizerFreeze <= 1'b0;
      txRateDiv <= 2'h0;
      gainLoopPolicy <= 2'h1;
      offsetCalMode <= 2'h0;
      rxFrontEnable <= 1'b0;
      rxRateDiv <= 3'h0;
    end
    else
    begin
      txAmplitudeSel <= lineDrive[`AMP_MSB:`AMP_LSB];
      txDriverEnable <= next_txDriverEnable;
      equalizerFreeze <= lineDrive[`EQ_FREEZE_BIT];
      txRateDiv <= lineDrive[`TX_RATE_MSB:`TX_RATE_LSB];
      gainLoopPolicy <= lineDrive[`GAIN_MSB:`GAIN_LSB];
      offsetCalMode <= lineDrive[`CAL_MSB:`CAL_LSB];
      rxFrontEnable <= next_rxFrontEnable;
      rxRateDiv <= lineDrive[`RX_RATE_MSB:`RX_RATE_LSB];
    end
  end

  // static receive tuning outputs, one cycle behind the stored word
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      adcTrackForce <= 1'b0;
      rxPrecursorEq <= 3'h1;
      recoveryLoopOrder <= 2'h1;
      recoveryVoteThreshold <= 2'h1;
      hfPeakingOff <= 1'b0;
      shortChannelRecovery <= 1'b0;
      txCursorReduction <= 5'h00;
    end
    else
    begin
      adcTrackForce <= receiveTune[`TRACK_BIT];
      rxPrecursorEq <= receiveTune[`PRE_EQ_MSB:`PRE_EQ_LSB];
      recoveryLoopOrder <= receiveTune[`LOOP_MSB:`LOOP_LSB];
      recoveryVoteThreshold <= receiveTune[`VOTE_MSB:`VOTE_LSB];
      hfPeakingOff <= receiveTune[`PEAK_OFF_BIT];
      shortChannelRecovery <= receiveTune[`SHORT_CH_BIT];
      txCursorReduction <= receiveTune[`CURSOR_MSB:`CURSOR_LSB];
    end
  end
endmodule // hs_serdes_tuning_regs
`default_nettype wire

/* testbench/hs_tuning_asserts.sv */
`default_nettype none
module hs_tuning_asserts (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic mdc,
  input wire logic mdioOut,
  input wire logic mdioOe,
  input wire logic channelPowerdownPinN,
  input wire logic globalPowerDown,
  input wire logic [3:0] txAmplitudeSel,
  input wire logic [10:0] txSwingMv,
  input wire logic txDriverEnable,
  input wire logic rxFrontEnable,
  input wire logic [1:0] gainLoopPolicy,
  input wire logic [2:0] rxRateDiv,
  input wire logic [2:0] rxPrecursorEq,
  input wire logic [1:0] recoveryLoopOrder,
  input wire logic [4:0] txCursorReduction
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [10:0] SWING [16] = '{130, 220, 300, 390, 480, 570, 660, 750,
    830, 930, 1020, 1110, 1180, 1270, 1340, 1400};
  logic prevMdc;
  logic [2:0] sinceRise;
  logic [2:0] sinceFall;
  // saturating ages of the last mdc edges; outputs may only move shortly after one
  always @(posedge mclk)
  begin
    prevMdc <= mdc;
    sinceRise <= sys_rst ? 3'h7 : (mdc && !prevMdc) ? 3'h0 : sinceRise + {2'h0, sinceRise != 3'h7};
    sinceFall <= sys_rst ? 3'h7 : (!mdc && prevMdc) ? 3'h0 : sinceFall + {2'h0, sinceFall != 3'h7};
  end
  sequence pdAsserted;
    !channelPowerdownPinN || globalPowerDown;
  endsequence
  a_pd_disables: assert property (@(posedge mclk) disable iff (sys_rst)
    pdAsserted |=> !txDriverEnable && !rxFrontEnable) else $error("enable high in power down");
  a_tx_gate: assert property (@(posedge mclk) disable iff (sys_rst)
    txDriverEnable |-> $past(channelPowerdownPinN) && !$past(globalPowerDown))
    else $error("transmit enable not gated");
  a_rx_gate: assert property (@(posedge mclk) disable iff (sys_rst)
    rxFrontEnable |-> $past(channelPowerdownPinN) && !$past(globalPowerDown))
    else $error("receive enable not gated");
  a_swing_map: assert property (@(posedge mclk) disable iff (sys_rst)
    !$past(sys_rst) |-> txSwingMv == SWING[$past(txAmplitudeSel)]) else $error("swing map wrong");
  a_reset_drive: assert property (@(posedge mclk)
    sys_rst |=> txAmplitudeSel == 4'hA && gainLoopPolicy == 2'h1 && rxRateDiv == 3'h0
    && !txDriverEnable && !mdioOe) else $error("line drive reset wrong");
  a_reset_tune: assert property (@(posedge mclk)
    sys_rst |=> rxPrecursorEq == 3'h1 && recoveryLoopOrder == 2'h1 && txCursorReduction == 5'h00)
    else $error("tune reset wrong");
  a_field_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    $changed({txAmplitudeSel, gainLoopPolicy, rxRateDiv, rxPrecursorEq, recoveryLoopOrder,
    txCursorReduction}) |-> sinceRise < 3'h6) else $error("field moved without a write");
  a_mdio_timing: assert property (@(posedge mclk) disable iff (sys_rst)
    $changed({mdioOut, mdioOe}) |-> sinceFall < 3'h5) else $error("mdio moved off a fall");
endmodule // hs_tuning_asserts
bind hs_serdes_tuning_regs hs_tuning_asserts i_chk (.mclk, .sys_rst, .mdc, .mdioOut, .mdioOe,
  .channelPowerdownPinN, .globalPowerDown, .txAmplitudeSel, .txSwingMv, .txDriverEnable,
  .rxFrontEnable, .gainLoopPolicy, .rxRateDiv, .rxPrecursorEq, .recoveryLoopOrder,
  .txCursorReduction);
`default_nettype wire

/* testbench/testbench.sv */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic mdc = 1'b0;
  logic tbData = 1'b1;
  logic [4:0] phyAddr = 5'h05;
  logic channelPowerdownPinN = 1'b1;
  logic globalPowerDown = 1'b0;
  logic [15:0] rv;
  logic [15:0] rvOe;
  int err_total = 0;
  int tests_run = 0;
  int cycles = 0;
  wire logic mdioIn, mdioOut, mdioOe;
  wire logic [10:0] txSwingMv;
  wire logic [3:0] txAmplitudeSel;
  wire logic [2:0] rxRateDiv, rxPrecursorEq;
  wire logic [1:0] txRateDiv, gainLoopPolicy, offsetCalMode;
  wire logic [1:0] recoveryLoopOrder, recoveryVoteThreshold;
  wire logic [4:0] txCursorReduction;
  wire logic txDriverEnable, equalizerFreeze, rxFrontEnable, adcTrackForce, hfPeakingOff;
  wire logic shortChannelRecovery;
  wire logic [15:0] driveOut = {txAmplitudeSel, txDriverEnable, equalizerFreeze, txRateDiv,
    gainLoopPolicy, offsetCalMode, rxFrontEnable, rxRateDiv};
  wire logic [15:0] tuneOut = {adcTrackForce, rxPrecursorEq, recoveryLoopOrder,
    recoveryVoteThreshold, 1'b0, hfPeakingOff, shortChannelRecovery, txCursorReduction};
  // released line floats high through the pull-up
  assign mdioIn = mdioOe ? mdioOut : tbData;
  always #2 mclk = ~mclk;
  hs_serdes_tuning_regs i_dut (
    .mclk(mclk), .sys_rst(sys_rst), .mdc(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut),
    .mdioOe(mdioOe), .phyAddr(phyAddr), .channelPowerdownPinN(channelPowerdownPinN),
    .globalPowerDown(globalPowerDown), .txAmplitudeSel(txAmplitudeSel),
    .txSwingMv(txSwingMv), .txDriverEnable(txDriverEnable), .equalizerFreeze(equalizerFreeze),
    .txRateDiv(txRateDiv), .gainLoopPolicy(gainLoopPolicy), .offsetCalMode(offsetCalMode),
    .rxFrontEnable(rxFrontEnable), .rxRateDiv(rxRateDiv), .adcTrackForce(adcTrackForce),
    .rxPrecursorEq(rxPrecursorEq), .recoveryLoopOrder(recoveryLoopOrder),
    .recoveryVoteThreshold(recoveryVoteThreshold), .hfPeakingOff(hfPeakingOff),
    .shortChannelRecovery(shortChannelRecovery), .txCursorReduction(txCursorReduction)
  );
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
  begin
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  end
  endtask
  // mdc phases of 4 mclk; read bits sampled just before each rise
  task automatic frame(input logic [1:0] op, input logic [4:0] ad, input logic [4:0] rg,
      input logic [15:0] wd);
    logic [63:0] f;
  begin
    f = {32'hFFFFFFFF, 2'b01, op, ad, rg, op == 2'b01 ? 2'b10 : 2'b11, wd};
    for (int i = 63; i >= 0; i--)
    begin
      mdc = 1'b0;
      tbData = f[i];
      repeat (4) @(negedge mclk);
      if (i < 16)
      begin
        rv[i] = mdioIn;
        rvOe[i] = mdioOe;
      end
      mdc = 1'b1;
      repeat (4) @(negedge mclk);
    end
    tbData = 1'b1;
    repeat (8) @(negedge mclk);
  end
  endtask
  task automatic t_reset;
  begin
    sys_rst = 1'b1;
    // mdc sits low when reset ends, else the first edge looks like a rise
    mdc = 1'b0;
    repeat (6) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (3) @(negedge mclk);
    chk("drive", driveOut, 16'hA848);
    chk("tune", tuneOut, 16'h1500);
    chk("swing", {5'h00, txSwingMv}, 16'h03FC);
    frame(2'b10, phyAddr, 5'h03, 16'hFFFF);
    chk("read drive", rv, 16'hA848);
    frame(2'b10, phyAddr, 5'h04, 16'hFFFF);
    chk("read tune", rv, 16'h1500);
  end
  endtask
  task automatic t_codes;
    logic [15:0] d;
    logic [15:0] t;
    logic [15:0] sw [4];
  begin
    sw = '{16'h0082, 16'h023A, 16'h03FC, 16'h0578};
    for (int i = 0; i < 4; i++)
    begin
      d = {4'(i * 5), 1'b1, 1'(i), 2'(i), 2'(i), 2'(i), 1'b1, i == 0 ? 3'h0 : 3'(4 + i)};
      t = {1'(i), 2'(i), 1'b1, i == 3 ? 2'h2 : 2'(i), 2'(i), 1'b0, 1'(i >> 1), 1'(i),
        1'(i >> 1), 2'h0, 2'(i)};
      frame(2'b01, phyAddr, 5'h03, d);
      frame(2'b01, phyAddr, 5'h04, t);
      chk("drive out", driveOut, d);
      chk("tune out", tuneOut, t);
      chk("swing", {5'h00, txSwingMv}, sw[i]);
      frame(2'b10, phyAddr, 5'h03, 16'hFFFF);
      chk("read drive", rv, d);
      frame(2'b10, phyAddr, 5'h04, 16'hFFFF);
      chk("read tune", rv, t);
    end
  end
  endtask
  task automatic t_power;
  begin
    channelPowerdownPinN = 1'b0;
    repeat (2) @(negedge mclk);
    chk("pin off", {14'h0, txDriverEnable, rxFrontEnable}, 16'h0000);
    frame(2'b10, phyAddr, 5'h03, 16'hFFFF);
    chk("bits kept", rv, 16'hFFFF);
    chk("bits driven", rvOe, 16'hFFFF);
    channelPowerdownPinN = 1'b1;
    globalPowerDown = 1'b1;
    repeat (2) @(negedge mclk);
    chk("global off", {14'h0, txDriverEnable, rxFrontEnable}, 16'h0000);
    globalPowerDown = 1'b0;
    repeat (2) @(negedge mclk);
    chk("back on", {14'h0, txDriverEnable, rxFrontEnable}, 16'h0003);
  end
  endtask
  task automatic t_refused;
  begin
    frame(2'b01, phyAddr ^ 5'h01, 5'h03, 16'h0000);
    frame(2'b01, phyAddr, 5'h05, 16'h0000);
    chk("drive kept", driveOut, 16'hFFFF);
    // a read leaves the line to the pull-up
    frame(2'b10, phyAddr, 5'h05, 16'hFFFF);
    chk("unmapped", rv, 16'hFFFF);
    chk("unmapped quiet", rvOe, 16'h0000);
  end
  endtask
  task automatic results;
  begin
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  // the 24 frames of 520 cycles fit well inside this ceiling
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      err_total++;
      results();
    end
  end
  initial
  begin
    t_reset();
    t_codes();
    t_power();
    t_refused();
    t_reset();
    results();
  end
endmodule // testbench
`default_nettype wire
